// File: core/hbridge_pwm_generator.sv
// Five-output pulse-width generator with an AHB-Lite register slave.
`timescale 1ns/1ps

module hbridge_pwm_generator
   import pwm_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Waveform outputs.
   output logic high_side_out_a,
   output logic low_side_out_a,
   output logic high_side_out_b,
   output logic low_side_out_b,
   output logic single_out_c,
   // Period event still waiting for software.
   output logic period_event_pending
);

   // ****************************************************************
   // Bus slave.
   // ****************************************************************
   // Address phase request, held for the data phase.
   bus_req_t req_q;
   // Registered read data.
   logic [31:0] rdata_q;
   // Every register as seen by a read, by word index.
   logic [15:0][31:0] view;

   // A transfer is taken when selected, non-idle and the bus is ready.
   wire take = hsel & htrans[1] & hready;
   // Only aligned whole words inside the block's window are mapped.
   wire in_win = (haddr[31:6] == BASE_ADDR[31:6]);
   wire aligned = (haddr[1:0] == 2'b00) & (hsize == 3'b010);
   wire mapped = in_win & aligned;
   wire [3:0] a_idx = haddr[5:2];
   // Write strobe for the data phase, with its target word.
   wire wr_en = req_q.valid & req_q.wr;
   wire [15:0] wdata = hwdata[15:0];

   // The slave never inserts waits and never reports an error.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // Limitation: a read pipelined straight behind a write to the same
   // word returns the old value; single transfers never do that.
   // Capture the request; read data are fetched in the address phase
   // so they stand from a flip-flop for the whole data phase.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_q <= '0;
         rdata_q <= 32'h00000000;
      end else begin
         req_q <= '{valid: take & mapped, wr: hwrite, idx: a_idx};
         if (take & ~hwrite & mapped) begin
            rdata_q <= view[a_idx];
         end else begin
            // Unmapped reads and idle cycles return zero.
            rdata_q <= 32'h00000000;
         end
      end
   end

   // ****************************************************************
   // Control word and prescaler.
   // ****************************************************************
   // Software-visible control word.
   logic [15:0] ctrl_q;
   // Free-running divider of the core clock.
   logic [DIV_W-1:0] div_q;

   wire wr_ctrl = wr_en & (req_q.idx == IDX_CTRL);
   wire bridge_mode_select = ctrl_q[B_BRIDGE];
   wire compare_load_request = ctrl_q[B_LOAD];
   wire high_side_force_off = ctrl_q[B_FORCE];
   wire [PRESC_W-1:0] clock_prescale_select = ctrl_q[B_PRESC +: PRESC_W];
   // Code n divides by 2^(n+1): the low n+1 bits of the divider.
   wire [DIV_W:0] div_mask = (9'h002 << clock_prescale_select) - 9'h001;
   // One timer step every 2..256 core clocks.
   wire tick = &(div_q | ~div_mask[DIV_W-1:0]);

   // Reset leaves bridge mode with the high sides forced, motor off.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= wdata & CTRL_MASK;
      end
   end

   // The divider runs always; changing the code mid-count only
   // shortens or stretches the step in progress.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // ****************************************************************
   // Pair timers, compare shadows and waveforms.
   // ****************************************************************
   // Programmed values as written by software.
   pair_cfg_t cfg_q [PAIRS];
   // Active compares that the waveforms really use.
   pair_cfg_t act_q [PAIRS];
   // One 16-bit timer per pair.
   logic [CNT_W-1:0] cnt_q [PAIRS];
   // Raw high-side and low-side levels of each pair.
   logic [PAIRS-1:0] hi_q;
   logic [PAIRS-1:0] lo_q;

   for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      // Word indices of this pair's settings.
      localparam logic [3:0] I0 = 4'(IDX_PAIR0 + FIELDS * p);
      // The single output has no low-side compare word.
      localparam bit HAS_LOW = (p < PAIRS - 1);
      wire wr_rise = wr_en & (req_q.idx == I0 + 4'(F_RISE));
      wire wr_fall = wr_en & (req_q.idx == I0 + 4'(F_FALL));
      wire wr_low = wr_en & HAS_LOW & (req_q.idx == I0 + 4'(F_LOW));
      wire wr_len = wr_en & (req_q.idx == I0 + 4'(F_LEN));
      // End of the period, when the timer wraps to zero.
      wire at_len = (cnt_q[p] == cfg_q[p].len);
      // Timer step from zero to one: the only moment compares load.
      wire step01 = tick & (cnt_q[p] == '0) & ~at_len;
      // Compare matches against the active values.
      wire m_rise = (cnt_q[p] == act_q[p].rise);
      wire m_fall = (cnt_q[p] == act_q[p].fall);
      wire m_low = HAS_LOW & (cnt_q[p] == act_q[p].low_fall);
      // High side: set at compare 0, cleared at compare 1 (clear wins).
      wire hi_d = (hi_q[p] | m_rise) & ~m_fall;
      wire hi_falls = hi_q[p] & ~hi_d;
      // Low side: set at the length, cleared at compare 2 or when the
      // high side falls, whichever comes first.
      wire lo_d = HAS_LOW & (lo_q[p] | at_len) & ~m_low & ~hi_falls;

      // Programmed settings; a pair's words are its own alone.
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            cfg_q[p] <= '{default: CFG_RESET};
         end else begin
            if (wr_rise) cfg_q[p].rise <= wdata;
            if (wr_fall) cfg_q[p].fall <= wdata;
            if (wr_low) cfg_q[p].low_fall <= wdata;
            if (wr_len) cfg_q[p].len <= wdata;
         end
      end

      // Shadow compares: copied only at the start of a new count, so a
      // period never runs on a half-written set of values.
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            act_q[p] <= '{default: CFG_RESET};
         end else if (compare_load_request & step01) begin
            act_q[p] <= cfg_q[p];
         end
      end

      // Timer counts 0..length on each prescaled step, then restarts.
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            cnt_q[p] <= '0;
         end else if (tick) begin
            cnt_q[p] <= at_len ? '0 : cnt_q[p] + 16'h0001;
         end
      end

      // Waveform levels follow the count one core clock later.
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            hi_q[p] <= 1'b0;
            lo_q[p] <= 1'b0;
         end else begin
            hi_q[p] <= hi_d;
            lo_q[p] <= lo_d;
         end
      end

      // Read views of this pair's words.
      assign view[I0 + 4'(F_RISE)] = {16'h0000, cfg_q[p].rise};
      assign view[I0 + 4'(F_FALL)] = {16'h0000, cfg_q[p].fall};
      assign view[I0 + 4'(F_LEN)] = {16'h0000, cfg_q[p].len};
      if (HAS_LOW) begin : g_low
         assign view[I0 + 4'(F_LOW)] = {16'h0000, cfg_q[p].low_fall};
      end else begin : g_nolow
         assign view[I0 + 4'(F_LOW)] = 32'h00000000;
      end
   end

   // ****************************************************************
   // Pending period event.
   // ****************************************************************
   // Raised when pair A's timer wraps, dropped by any write to the
   // clear word; an event in the clearing cycle survives.
   logic pend_q;
   wire pend_set = tick & (cnt_q[0] == cfg_q[0].len);
   wire pend_clr = wr_en & (req_q.idx == IDX_CLEAR);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_set | (pend_q & ~pend_clr);
      end
   end

   assign period_event_pending = pend_q;

   // Remaining read views: control, clear, status and unmapped words.
   assign view[IDX_CTRL] = {16'h0000, ctrl_q};
   assign view[IDX_CLEAR] = 32'h00000000;
   assign view[IDX_STATUS] = {15'h0000, pend_q, cnt_q[0]};
   assign view[15] = 32'h00000000;

   // ****************************************************************
   // Output stage.
   // ****************************************************************
   // Registered pin levels, in order 0..4.
   logic [4:0] out_q;
   // In bridge mode a low side is held off while its high side is on,
   // so the two switches of a leg never conduct together.
   wire lo_a = lo_q[0] & ~(bridge_mode_select & hi_q[0]);
   wire lo_b = lo_q[1] & ~(bridge_mode_select & hi_q[1]);
   // Forcing drives both high sides on and both low sides off.
   // Output 4 has no partner switch, so forcing leaves it running.
   wire [4:0] out_d = high_side_force_off ?
      {hi_q[2], 1'b0, 1'b1, 1'b0, 1'b1} :
      {hi_q[2], lo_b, hi_q[1], lo_a, hi_q[0]};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         // Same safe levels as the forced state at power-up.
         out_q <= OUT_RESET;
      end else begin
         out_q <= out_d;
      end
   end

   assign high_side_out_a = out_q[0];
   assign low_side_out_a = out_q[1];
   assign high_side_out_b = out_q[2];
   assign low_side_out_b = out_q[3];
   assign single_out_c = out_q[4];

   // ****************************************************************
   // Elaboration checks.
   // ****************************************************************
   // The pair groups must end below the clear word, or two registers
   // would share an index and one write would land in both.
   if (int'(IDX_PAIR0) + FIELDS * PAIRS > int'(IDX_CLEAR)) begin : g_map_check
      $error("pair register groups overlap the clear word");
   end
   // Code 7 needs eight divider bits; a shorter divider would wrap
   // before the slowest step and run that code too fast.
   if (DIV_W < (1 << PRESC_W)) begin : g_div_check
      $error("divider too short for the prescaler codes");
   end
   // Timer words are written through the low half of the data bus.
   if (CNT_W > 16) begin : g_cnt_check
      $error("timer wider than the register data");
   end

endmodule

// File: dv/hbridge_pwm_generator_asserts.sv
// Checker of the bus answers and output relations of the waveform generator.
`timescale 1ns/1ps
module hbridge_pwm_checker
   import pwm_pkg::*;
(
   // Clock, reset and bus.
   input wire logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   // Waveform outputs and pending flag.
   input wire logic high_side_out_a, low_side_out_a, high_side_out_b, low_side_out_b,
   input wire logic single_out_c, period_event_pending
);
   // ****************************************************************
   // Mirror of bus accesses, so the checks know the control word.
   // ****************************************************************
   wire take = hsel && htrans[1] && hready && hsize == 3'h2;
   wire at_ctrl = haddr == BASE_ADDR;
   wire at_clr = haddr == BASE_ADDR + 32'h34;
   logic [15:0] ctrl_q;
   logic cw_q, cr_q, clr_q, any_q;
   // The mirror updates at the end of the data phase, as the slave does.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {cw_q, cr_q, clr_q, any_q} <= 4'h0;
         ctrl_q <= CTRL_RESET;
      end else begin
         cw_q <= take && hwrite && at_ctrl;
         cr_q <= take && !hwrite && at_ctrl;
         clr_q <= take && hwrite && at_clr;
         any_q <= hsel && htrans[1] && hready;
         if (cw_q) ctrl_q <= hwdata[15:0] & CTRL_MASK;
      end
   end
   wire force_on = ctrl_q[B_FORCE];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
   property p_idle; !any_q |-> hrdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside data phase");
   property p_upper; hrdata[31:17] == 15'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read data bits set");
   property p_ctrl; cr_q |-> hrdata == {16'h0, ctrl_q}; endproperty
   a_ctrl: assert property (p_ctrl) else $error("control word read mismatch");
   // Three settled cycles give the output flops time to follow the force bit.
   property p_force; force_on [*3] |=> high_side_out_a && !low_side_out_a &&
      high_side_out_b && !low_side_out_b; endproperty
   a_force: assert property (p_force) else $error("forced levels not held");
   property p_fall_a; $fell(high_side_out_a) && !force_on && !$past(force_on, 4)
      |-> ##[0:1] !low_side_out_a; endproperty
   a_fall_a: assert property (p_fall_a) else $error("low side a kept high");
   property p_fall_b; $fell(high_side_out_b) && !force_on && !$past(force_on, 4)
      |-> ##[0:1] !low_side_out_b; endproperty
   a_fall_b: assert property (p_fall_b) else $error("low side b kept high");
   property p_clear; clr_q |=> !period_event_pending; endproperty
   a_clear: assert property (p_clear) else $error("pending not cleared");
   property p_sticky; $fell(period_event_pending) |-> $past(clr_q); endproperty
   a_sticky: assert property (p_sticky) else $error("pending dropped by itself");
   c_read: cover property (cr_q);
   c_clear: cover property (clr_q && period_event_pending);
   c_fall: cover property ($fell(high_side_out_b));
endmodule

// File: dv/hbridge_pwm_generator_tb.sv
// Self-checking bench of the five-output waveform generator.
`timescale 1ns/1ps
module hbridge_pwm_generator_tb;
   import pwm_pkg::*;
   // ****************************************************************
   // Signals, design, power stage.
   // ****************************************************************
   logic clk, resetn, hsel, hwrite, hreadyout, hresp, shoot_q;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic high_side_out_a, low_side_out_a, high_side_out_b, low_side_out_b;
   logic single_out_c, period_event_pending;
   int err_count, tests_run, cycles;
   // Watched levels, pending flag on top.
   wire [5:0] outs = {period_event_pending, single_out_c, low_side_out_b,
      high_side_out_b, low_side_out_a, high_side_out_a};
   hbridge_pwm_generator DUT (.*, .hready(hreadyout));
   hbridge_stage_model stage (.clk(clk), .resetn(resetn), .gate_hi_a(high_side_out_a),
      .gate_lo_a(low_side_out_a), .gate_hi_b(high_side_out_b),
      .gate_lo_b(low_side_out_b), .shoot_q(shoot_q));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // A hang ends the run as a failure.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         final_report();
      end
   end
   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic final_report();
      if (err_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single word transfer; the address phase is held until hready.
   task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] wd,
         output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= BASE_ADDR + {26'h0, i, 2'h0};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic edge_wait(input int s, input logic v, output int n);
      n = 0;
      while (outs[s] !== v && n < 9000) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Two periods are skipped first, since shadows load only as a new count starts.
   task automatic measure(input int s, input int hi, input int per);
      int n, h;
      repeat (2) begin
         edge_wait(s, 1'b0, n);
         edge_wait(s, 1'b1, n);
      end
      edge_wait(s, 1'b0, h);
      edge_wait(s, 1'b1, n);
      chk(h, hi);
      chk(h + n, per);
   endtask
   task automatic prog(input logic [3:0] b, input logic [15:0] r, f, l, n);
      bus(1'b1, b, {16'h0, r}, rd);
      bus(1'b1, b + 4'h1, {16'h0, f}, rd);
      bus(1'b1, b + 4'h2, {16'h0, l}, rd);
      bus(1'b1, b + 4'h3, {16'h0, n}, rd);
      bus(1'b0, b + 4'h3, 32'h0, rd);
      chk(rd, {16'h0, n});
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic s_regs();
      bus(1'b0, IDX_CTRL, 32'h0, rd);
      chk(rd, 32'h12);
      // Pair A's zero length wraps on every step, so pending is already up.
      chk({26'h0, outs}, 32'h25);
      bus(1'b1, IDX_CTRL, 32'hffff, rd);
      bus(1'b0, IDX_CTRL, 32'h0, rd);
      chk(rd, 32'h5fff);
      for (int i = 11; i < 16; i += 4) begin
         bus(1'b1, i[3:0], 32'h1234, rd);
         bus(1'b0, i[3:0], 32'h0, rd);
         chk(rd, 32'h0);
      end
      prog(IDX_PAIR0, 16'h2, 16'h4, 16'h0, 16'h6);
      prog(IDX_PAIR0 + 4'h4, 16'h3, 16'h6, 16'h1, 16'h8);
      prog(IDX_PAIR0 + 4'h8, 16'h3, 16'h4, 16'h0, 16'h4);
   endtask
   // Every prescaler code, standard mode, loading on.
   task automatic s_rates();
      int d;
      for (int c = 0; c < 8; c++) begin
         d = 2 << c;
         bus(1'b1, IDX_CTRL, {23'h0, c[2:0], 6'h8}, rd);
         measure(0, 2 * d, 7 * d);
         measure(1, d, 7 * d);
      end
      measure(2, 6 << 7, 18 << 7);
      bus(1'b1, IDX_CTRL, 32'h8, rd);
      measure(3, 4, 18);
      measure(4, 2, 10);
   endtask
   task automatic s_force();
      bus(1'b1, IDX_CTRL, 32'h18, rd);
      repeat (3) @(posedge clk);
      repeat (30) begin
         @(posedge clk);
         chk({28'h0, outs[3:0]}, 32'h5);
      end
      measure(4, 2, 10);
      // Bridge mode with loading off keeps the old fall point.
      bus(1'b1, IDX_CTRL, 32'h2, rd);
      bus(1'b1, IDX_PAIR0 + 4'h1, 32'h5, rd);
      measure(0, 4, 14);
      bus(1'b1, IDX_CTRL, 32'ha, rd);
      measure(0, 6, 14);
   endtask
   task automatic s_pend();
      int n;
      bus(1'b1, IDX_CTRL, 32'h1ca, rd);
      // Clear just after pair A wraps, so no new event meets the clear.
      edge_wait(1, 1'b1, n);
      edge_wait(1, 1'b0, n);
      bus(1'b1, IDX_CLEAR, 32'h0, rd);
      bus(1'b0, IDX_STATUS, 32'h0, rd);
      chk({31'h0, rd[B_PEND]}, 32'h0);
      chk({31'h0, rd[15:0] <= 16'h6}, 32'h1);
      edge_wait(5, 1'b1, n);
      chk({31'h0, n < 1900}, 32'h1);
      bus(1'b0, IDX_STATUS, 32'h0, rd);
      chk({31'h0, rd[B_PEND]}, 32'h1);
   endtask
   initial begin
      {resetn, hsel, hwrite, htrans} = 5'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      hsize = 3'h2;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      s_regs();
      s_rates();
      s_force();
      s_pend();
      chk({31'h0, shoot_q}, 32'h0);
      final_report();
   end
endmodule
bind hbridge_pwm_generator hbridge_pwm_checker u_chk (.*);

// File: dv/hbridge_stage_model.sv
// Behavioural H-bridge power stage driven by the four gate outputs.
`timescale 1ns/1ps
module hbridge_stage_model (
   // Clock and reset.
   input wire logic clk, resetn,
   // Gate drives of the two legs.
   input wire logic gate_hi_a, gate_lo_a, gate_hi_b, gate_lo_b,
   // Sticky flag: a leg once had both switches on.
   output logic shoot_q
);
   // Both switches of one leg on shorts the supply, so it is remembered.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) shoot_q <= 1'b0;
      else if ((gate_hi_a && gate_lo_a) || (gate_hi_b && gate_lo_b)) shoot_q <= 1'b1;
   end
endmodule

// File: inc/pwm_pkg.sv
// Shared constants and carrier types of the five-output waveform generator.
package pwm_pkg;

   // ****************************************************************
   // Register map.
   // ****************************************************************
   // Byte address of the waveform control word; the rest follow it.
   localparam logic [31:0] BASE_ADDR = 32'hffff0f80;
   // Word indices from the base (byte address = base + 4 * index).
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_PAIR0 = 4'h1;
   localparam int FIELDS = 4;
   localparam logic [3:0] IDX_CLEAR = 4'hd;
   localparam logic [3:0] IDX_STATUS = 4'he;
   // Field order inside one pair's group of words.
   localparam int F_RISE = 0;
   localparam int F_FALL = 1;
   localparam int F_LOW = 2;
   localparam int F_LEN = 3;

   // ****************************************************************
   // Control word layout and reset values.
   // ****************************************************************
   localparam logic [15:0] CTRL_RESET = 16'h0012;
   // Bits 13 and 15 are reserved and always read zero.
   localparam logic [15:0] CTRL_MASK = 16'h5fff;
   localparam int B_BRIDGE = 1;
   localparam int B_LOAD = 3;
   localparam int B_FORCE = 4;
   localparam int B_PRESC = 6;
   localparam int PRESC_W = 3;
   // Status word: bit 16 is the pending flag, 15:0 the pair A count.
   localparam int B_PEND = 16;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // Pin levels 0..4 at reset: high sides on, low sides and output 4 off.
   localparam logic [4:0] OUT_RESET = 5'h05;

   // ****************************************************************
   // Structure.
   // ****************************************************************
   localparam int PAIRS = 3;
   localparam int CNT_W = 16;
   localparam int DIV_W = 8;

   // Programmed or active settings of one output pair.
   typedef struct packed {
      logic [CNT_W-1:0] len;
      logic [CNT_W-1:0] low_fall;
      logic [CNT_W-1:0] fall;
      logic [CNT_W-1:0] rise;
   } pair_cfg_t;

   // Bus access captured in the address phase.
   typedef struct packed {
      logic valid;
      logic wr;
      logic [3:0] idx;
   } bus_req_t;

endpackage
